// [inc/sfid_pkg.sv]
package sfid_pkg;

  // ***************************************************************
  // Opcodes
  // ***************************************************************
  localparam logic [7:0] OPC_SECURE_READ = 8'h48;
  localparam logic [7:0] OPC_SLEEP = 8'hb9;
  localparam logic [7:0] OPC_WAKE = 8'hab;
  localparam logic [7:0] OPC_MAKER_PART = 8'h90;
  localparam logic [7:0] OPC_DUAL_ID = 8'h92;
  localparam logic [7:0] OPC_QUAD_ID = 8'h94;
  localparam logic [7:0] OPC_THREE_ID = 8'h9f;

  // ***************************************************************
  // Frame lengths, in serial clocks
  // ***************************************************************
  localparam logic [4:0] OPC_CLKS = 5'h08;
  localparam logic [4:0] ADDR_CLKS_ONE = 5'h18;
  localparam logic [4:0] ADDR_CLKS_TWO = 5'h0c;
  localparam logic [4:0] ADDR_CLKS_FOUR = 5'h06;
  localparam logic [4:0] MODE_CLKS_TWO = 5'h04;
  localparam logic [4:0] MODE_CLKS_FOUR = 5'h02;
  localparam logic [4:0] DUMMY_CLKS_SECURE = 5'h08;
  localparam logic [4:0] DUMMY_CLKS_SIG = 5'h18;
  localparam logic [4:0] DUMMY_CLKS_FOUR = 5'h04;

  // ***************************************************************
  // Address layout and values
  // ***************************************************************
  localparam int SECREG_NUM = 3;
  localparam logic [3:0] SECREG_FIRST = 4'h1;
  localparam logic [3:0] SECREG_LAST = 4'h3;
  localparam logic [7:0] QUAD_SWAP_ADDR = 8'h01;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int CLK_MHZ = 100;
  localparam int SLEEP_ENTRY_DELAY_NS = 3000;
  localparam int WAKE_DELAY_NS = 3000;
  localparam int WAKE_WITH_ID_DELAY_NS = 1800;
  // Entry is a least time (round up), wake delays are longest times (round down)
  localparam int SLEEP_ENTRY_CYC = (SLEEP_ENTRY_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int WAKE_CYC_RAW = (WAKE_DELAY_NS * CLK_MHZ) / 1000;
  localparam int WAKE_CYC = (WAKE_CYC_RAW < 1) ? 1 : WAKE_CYC_RAW;
  localparam int WAKE_ID_CYC_RAW = (WAKE_WITH_ID_DELAY_NS * CLK_MHZ) / 1000;
  localparam int WAKE_ID_CYC = (WAKE_ID_CYC_RAW < 1) ? 1 : WAKE_ID_CYC_RAW;
  localparam int TMR_W = 12;

  // ***************************************************************
  // Types
  // ***************************************************************
  typedef enum logic [1:0] {LN_ONE, LN_TWO, LN_FOUR} sfid_lanes_t;
  typedef enum {PH_OPC, PH_ADDR, PH_MODE, PH_DUMMY, PH_OUT, PH_ARMED, PH_IGNORE} sfid_phase_t;
  typedef enum {PW_STANDBY, PW_ENTER, PW_SLEEP, PW_WAKE} sfid_power_t;
  typedef enum {CM_NONE, CM_SECURE, CM_SLEEP, CM_SIG, CM_MAKER, CM_DUAL, CM_QUAD,
                CM_THREE} sfid_cmd_t;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic [3:0] io;
  } sfid_pins_t;

  typedef struct packed {
    logic [3:0] dout;
    logic [3:0] oe;
  } sfid_drive_t;

  typedef struct packed {
    logic en;
    logic [1:0] reg_sel;
    logic [7:0] addr;
    logic [7:0] data;
  } sfid_secwr_t;

  localparam sfid_pins_t PINS_IDLE = '{cs_n: 1'b1, sclk: 1'b0, io: 4'h0};
  localparam sfid_drive_t DRIVE_RST = '{dout: 4'h0, oe: 4'h0};

endpackage

// [design/sfid_core.sv]
`timescale 1ns/1ps
// Contract
// [R1] Secure read: 48h, 24-bit address, eight dummies
// [R2] Sample on rising edges, drive falling, MSB first
// [R3] Secure byte address increments, FFh wraps to 00h
// [R4] Address picks register one to three, low byte
// [R5] Secure read ignored while write in progress
// [R6] Sleep B9h only if select rises after opcode
// [R7] Valid sleep waits entry delay, then sleeps
// [R8] Asleep, every opcode except ABh is ignored
// [R9] Sleep command rejected while write in progress
// [R10] Select high gives standby; reset starts awake
// [R11] ABh alone wakes after the wake delay
// [R12] ABh plus three dummies repeats device byte
// [R13] ABh end: awake immediate, asleep delayed wake
// [R14] ABh not decoded while write in progress
// [R15] 90h plus zero address: maker then device
// [R16] 92h over two lines, alternating id bytes
// [R17] Host sends mode pair as one, zero
// [R18] 94h needs quad enable; four-line framing
// [R19] Quad address 01h puts device byte first
// [R20] 9Fh returns maker, type, capacity bytes
// [R21] Select rise ends three-byte id output
// [R22] 9Fh not decoded while write in progress
// [R23] Write-in-progress flag marks running cycles
// [R24] Quad address 00h puts maker byte first
// [R25] Host holds select low for whole command
module sfid_core #(
  parameter logic [7:0] MAKER_ID = 8'h5a,  // Arbitrary value
  parameter logic [7:0] DEVICE_ID = 8'h13,  // Arbitrary value
  parameter logic [7:0] MEM_TYPE = 8'h40,  // Arbitrary value
  parameter logic [7:0] CAPACITY = 8'h14,  // Arbitrary value
  parameter int SEC_BYTES = 256,
  parameter int BUF_DEPTH = 2
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // Serial pins
  input wire sfid_pkg::sfid_pins_t pins_i,
  output sfid_pkg::sfid_drive_t drive_o,
  // Program and erase engine
  input wire logic write_in_progress_flag_i,
  input wire logic quad_lines_enable_i,
  input wire sfid_pkg::sfid_secwr_t secwr_i,
  // Power state
  output logic deep_sleep_o
);
  import sfid_pkg::*;

  localparam int BUF_AW = (BUF_DEPTH < 2) ? 1 : $clog2(BUF_DEPTH);
  localparam int SEC_AW = $clog2(SECREG_NUM * SEC_BYTES);

  // ***************************************************************
  // Functions
  // ***************************************************************
  // Shift in the bits of one serial clock, lane count by width
  function automatic logic [31:0] shift_in(input logic [31:0] sr, input logic [3:0] io,
                                           input sfid_lanes_t ln);
    logic [31:0] r;
    r = {sr[30:0], io[0]};
    if (ln == LN_TWO) begin
      r = {sr[29:0], io[1:0]};
    end else if (ln == LN_FOUR) begin
      r = {sr[27:0], io};
    end
    return r;
  endfunction

  // Top bits of a byte placed on the lines; single width uses line 1
  function automatic logic [3:0] lane_out(input logic [7:0] b, input sfid_lanes_t ln);
    logic [3:0] r;
    r = {2'h0, b[7], 1'b0};
    if (ln == LN_TWO) begin
      r = {2'h0, b[7:6]};
    end else if (ln == LN_FOUR) begin
      r = b[7:4];
    end
    return r;
  endfunction

  function automatic logic [3:0] lane_mask(input sfid_lanes_t ln);
    logic [3:0] r;
    r = 4'h2;
    if (ln == LN_TWO) begin
      r = 4'h3;
    end else if (ln == LN_FOUR) begin
      r = 4'hf;
    end
    return r;
  endfunction

  // Clocks to move one byte at the given width, minus one
  function automatic logic [2:0] byte_clks(input sfid_lanes_t ln);
    logic [2:0] r;
    r = 3'h7;
    if (ln == LN_TWO) begin
      r = 3'h3;
    end else if (ln == LN_FOUR) begin
      r = 3'h1;
    end
    return r;
  endfunction

  // ***************************************************************
  // Pin synchronisers and edge detection
  // ***************************************************************
  sfid_pins_t pin_meta_r;
  sfid_pins_t pin_sync_r;
  logic sclk_d_r;
  logic cs_d_r;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_rise;

  // Two stages before any logic; the serial clock is only sampled, never used as a clock
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      pin_meta_r <= PINS_IDLE;
      pin_sync_r <= PINS_IDLE;
      sclk_d_r <= 1'b0;
      cs_d_r <= 1'b1;
    end else begin
      pin_meta_r <= pins_i;
      pin_sync_r <= pin_meta_r;
      sclk_d_r <= pin_sync_r.sclk;
      cs_d_r <= pin_sync_r.cs_n;
    end
  end

  assign sclk_rise = pin_sync_r.sclk & ~sclk_d_r & ~pin_sync_r.cs_n;
  assign sclk_fall = ~pin_sync_r.sclk & sclk_d_r & ~pin_sync_r.cs_n;
  assign cs_rise = pin_sync_r.cs_n & ~cs_d_r;

  // ***************************************************************
  // Command framing
  // ***************************************************************
  sfid_phase_t ph_r;
  sfid_cmd_t cmd_r;
  sfid_lanes_t lanes_r;
  sfid_power_t pw_r;
  logic [4:0] cnt_r;
  logic [4:0] len_r;
  logic [31:0] in_sr_r;
  logic [23:0] addr_r;
  logic [31:0] shifted;
  logic [7:0] opc_now;
  logic opc_done;
  logic phase_end;
  sfid_phase_t dec_ph;
  sfid_cmd_t dec_cmd;
  sfid_lanes_t dec_lanes;
  logic [4:0] dec_len;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  assign shifted = shift_in(in_sr_r, pin_sync_r.io, lanes_r);
  assign opc_now = {in_sr_r[6:0], pin_sync_r.io[0]};
  assign opc_done = sclk_rise && ph_r == PH_OPC && cnt_r == OPC_CLKS - 5'h01;
  assign phase_end = sclk_rise && cnt_r == len_r - 5'h01;

  // Opcode decode; anything not listed falls to ignore until select rises
  always_comb begin
    dec_ph = PH_IGNORE;
    dec_cmd = CM_NONE;
    dec_lanes = LN_ONE;
    dec_len = OPC_CLKS;
    // Asleep only the wake opcode gets through; entry and wake windows take nothing
    if (pw_r == PW_STANDBY || (pw_r == PW_SLEEP && opc_now == OPC_WAKE)) begin  // [R8]
      case (opc_now)
        OPC_SECURE_READ: if (!write_in_progress_flag_i) begin  // [R5] [R23]
          dec_ph = PH_ADDR;
          dec_cmd = CM_SECURE;
          dec_len = ADDR_CLKS_ONE;  // [R1]
        end
        OPC_SLEEP: if (!write_in_progress_flag_i) begin  // [R9]
          dec_ph = PH_ARMED;
          dec_cmd = CM_SLEEP;
        end
        OPC_WAKE: if (!write_in_progress_flag_i) begin  // [R14]
          dec_ph = PH_DUMMY;
          dec_cmd = CM_SIG;
          dec_len = DUMMY_CLKS_SIG;  // [R12]
        end
        OPC_MAKER_PART: begin
          dec_ph = PH_ADDR;
          dec_cmd = CM_MAKER;
          dec_len = ADDR_CLKS_ONE;  // [R15]
        end
        OPC_DUAL_ID: begin
          dec_ph = PH_ADDR;
          dec_cmd = CM_DUAL;
          dec_lanes = LN_TWO;
          dec_len = ADDR_CLKS_TWO;  // [R16]
        end
        OPC_QUAD_ID: if (quad_lines_enable_i) begin  // [R18]
          dec_ph = PH_ADDR;
          dec_cmd = CM_QUAD;
          dec_lanes = LN_FOUR;
          dec_len = ADDR_CLKS_FOUR;
        end
        OPC_THREE_ID: if (!write_in_progress_flag_i) begin  // [R22]
          dec_ph = PH_OUT;
          dec_cmd = CM_THREE;  // [R20]
        end
        default: dec_ph = PH_IGNORE;
      endcase
    end
  end

  // Phase sequencer; select high returns to opcode collection
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i || pin_sync_r.cs_n) begin  // [R10] [R21] [R25]
      ph_r <= PH_OPC;
      cmd_r <= CM_NONE;
      lanes_r <= LN_ONE;
      cnt_r <= 5'h00;
      len_r <= OPC_CLKS;
      in_sr_r <= 32'h0;
      addr_r <= 24'h0;
    end else if (sclk_rise) begin  // [R2]
      in_sr_r <= shifted;
      cnt_r <= phase_end ? 5'h00 : cnt_r + 5'h01;
      unique case (ph_r)
        PH_OPC: if (opc_done) begin
          ph_r <= dec_ph;
          cmd_r <= dec_cmd;
          lanes_r <= dec_lanes;
          len_r <= dec_len;
          cnt_r <= 5'h00;
        end
        PH_ADDR: if (phase_end) begin
          addr_r <= shifted[23:0];
          if (cmd_r == CM_SECURE) begin
            ph_r <= PH_DUMMY;
            len_r <= DUMMY_CLKS_SECURE;  // [R1]
          end else if (cmd_r == CM_DUAL) begin
            ph_r <= PH_MODE;
            len_r <= MODE_CLKS_TWO;
          end else if (cmd_r == CM_QUAD) begin
            ph_r <= PH_MODE;
            len_r <= MODE_CLKS_FOUR;
          end else begin
            ph_r <= PH_OUT;
          end
        end
        PH_MODE: if (phase_end) begin
          // Mode bits are taken as sent and not checked
          if (cmd_r == CM_QUAD) begin
            ph_r <= PH_DUMMY;
            len_r <= DUMMY_CLKS_FOUR;  // [R18]
          end else begin
            ph_r <= PH_OUT;
          end
        end
        PH_DUMMY: if (phase_end) begin
          ph_r <= PH_OUT;
        end
        PH_ARMED: ph_r <= PH_IGNORE;  // [R6]
        PH_OUT: ph_r <= PH_OUT;
        PH_IGNORE: ph_r <= PH_IGNORE;
      endcase
    end
  end

  secure_busy_a: assert property (opc_done && opc_now == OPC_SECURE_READ  // [R5]
      && write_in_progress_flag_i && !pin_sync_r.cs_n |=> ph_r == PH_IGNORE)
    else $error("secure read decoded while write in progress");
  sleep_busy_a: assert property (opc_done && opc_now == OPC_SLEEP  // [R9]
      && write_in_progress_flag_i |=> ph_r != PH_ARMED)
    else $error("sleep command armed while write in progress");
  sleep_filter_a: assert property (opc_done && pw_r == PW_SLEEP  // [R8]
      && opc_now != OPC_WAKE |=> ph_r == PH_IGNORE || ph_r == PH_OPC)
    else $error("opcode other than wake decoded while asleep");
  quad_gate_a: assert property (opc_done && opc_now == OPC_QUAD_ID  // [R18]
      && !quad_lines_enable_i |=> cmd_r != CM_QUAD)
    else $error("quad id read accepted without quad enable");
  three_busy_a: assert property (opc_done && opc_now == OPC_THREE_ID  // [R22]
      && write_in_progress_flag_i |=> cmd_r != CM_THREE)
    else $error("three-byte id decoded while write in progress");

  // ***************************************************************
  // Security register storage
  // ***************************************************************
  logic [7:0] sec_mem_r [SECREG_NUM * SEC_BYTES];
  logic sec_ok;
  logic [1:0] sec_sel;

  // Register selection from the upper address fields
  assign sec_ok = addr_r[23:16] == 8'h00 && addr_r[11:9] == 3'h0  // [R4]
      && addr_r[15:12] >= SECREG_FIRST && addr_r[15:12] <= SECREG_LAST;
  assign sec_sel = 2'(addr_r[15:12] - SECREG_FIRST);

  // Filled by the program engine; starts erased
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < SECREG_NUM * SEC_BYTES; i++) begin
        sec_mem_r[i] <= ERASED_BYTE;
      end
    end else if (secwr_i.en) begin
      sec_mem_r[SEC_AW'(secwr_i.reg_sel * SEC_BYTES + secwr_i.addr)] <= secwr_i.data;
    end
  end

  // ***************************************************************
  // Byte producer and two-entry buffer
  // ***************************************************************
  logic [7:0] buf_r [BUF_DEPTH];
  logic [BUF_AW-1:0] wp_r;
  logic [BUF_AW-1:0] rp_r;
  logic [BUF_AW:0] fill_r;
  logic push_ready;
  logic push_valid;
  logic pop_valid;
  logic pop_ready;
  logic [7:0] idx_r;
  logic [7:0] next_byte;
  logic [2:0] sh_left_r;

  assign push_ready = fill_r != (BUF_AW + 1)'(BUF_DEPTH);
  assign push_valid = ph_r == PH_OUT && !pin_sync_r.cs_n;
  assign pop_valid = fill_r != '0;
  assign pop_ready = sclk_fall && ph_r == PH_OUT && sh_left_r == 3'h0;

  // Byte for the current position of the stream
  always_comb begin
    next_byte = 8'h00;
    unique case (cmd_r)
      CM_SECURE: next_byte = sec_ok ? sec_mem_r[SEC_AW'(sec_sel * SEC_BYTES + idx_r)]
                                    : ERASED_BYTE;
      CM_SIG: next_byte = DEVICE_ID;  // [R12]
      CM_MAKER, CM_DUAL, CM_QUAD: next_byte = idx_r[0] ? DEVICE_ID : MAKER_ID;  // [R19] [R24]
      CM_THREE: next_byte = (idx_r == 8'h00) ? MAKER_ID
                          : (idx_r == 8'h01) ? MEM_TYPE : CAPACITY;  // [R20]
      CM_NONE, CM_SLEEP: next_byte = 8'h00;
    endcase
  end

  // Stream position: start byte from the address for secure and quad reads, zero for the rest, then advance per byte queued
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i || pin_sync_r.cs_n) begin
      idx_r <= 8'h00;
    end else if (sclk_rise && ph_r == PH_ADDR && phase_end) begin
      if (cmd_r == CM_SECURE) begin
        idx_r <= shifted[7:0];
      end else if (cmd_r == CM_QUAD) begin
        idx_r <= (shifted[7:0] == QUAD_SWAP_ADDR) ? 8'h01 : 8'h00;  // [R19] [R24]
      end
    end else if (push_valid && push_ready) begin
      if (cmd_r == CM_THREE) begin
        idx_r <= (idx_r == 8'h02) ? 8'h00 : idx_r + 8'h01;
      end else begin
        idx_r <= idx_r + 8'h01;  // [R3]
      end
    end
  end

  wrap_a: assert property (push_valid && push_ready && cmd_r == CM_SECURE  // [R3]
      && idx_r == 8'hff && !pin_sync_r.cs_n |=> idx_r == 8'h00)
    else $error("security byte address did not wrap to zero");

  // Buffer decouples the byte fetch from the shifter; select high flushes it
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i || pin_sync_r.cs_n) begin
      wp_r <= '0;
      rp_r <= '0;
      fill_r <= '0;
      for (int i = 0; i < BUF_DEPTH; i++) begin
        buf_r[i] <= 8'h00;
      end
    end else begin
      if (push_valid && push_ready) begin
        buf_r[wp_r] <= next_byte;
        wp_r <= (wp_r == BUF_AW'(BUF_DEPTH - 1)) ? '0 : wp_r + 1'b1;
      end
      if (pop_valid && pop_ready) begin
        rp_r <= (rp_r == BUF_AW'(BUF_DEPTH - 1)) ? '0 : rp_r + 1'b1;
      end
      fill_r <= fill_r + (BUF_AW + 1)'(push_valid && push_ready)
                       - (BUF_AW + 1)'(pop_valid && pop_ready);
    end
  end

  // ***************************************************************
  // Output shifter and line drive
  // ***************************************************************
  sfid_drive_t drive_r;
  logic [7:0] sh_r;

  // New bits go out only on a falling edge, most significant first
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      drive_r <= DRIVE_RST;
      sh_r <= 8'h00;
      sh_left_r <= 3'h0;
    end else if (pin_sync_r.cs_n) begin
      drive_r.oe <= 4'h0;  // [R21]
      sh_left_r <= 3'h0;
    end else if (sclk_fall && ph_r == PH_OUT) begin  // [R2]
      drive_r.oe <= lane_mask(lanes_r);
      if (sh_left_r != 3'h0) begin
        drive_r.dout <= lane_out(sh_r, lanes_r);
        sh_r <= (lanes_r == LN_FOUR) ? sh_r << 4 : (lanes_r == LN_TWO) ? sh_r << 2 : sh_r << 1;
        sh_left_r <= sh_left_r - 3'h1;
      end else if (pop_valid) begin
        // An empty buffer holds the last bits; prefetch keeps this from happening
        drive_r.dout <= lane_out(buf_r[rp_r], lanes_r);
        sh_r <= (lanes_r == LN_FOUR) ? buf_r[rp_r] << 4
              : (lanes_r == LN_TWO) ? buf_r[rp_r] << 2 : buf_r[rp_r] << 1;
        sh_left_r <= byte_clks(lanes_r);
      end
    end
  end

  assign drive_o = drive_r;

  out_edge_a: assert property (!$stable(drive_r.dout) |-> $past(sclk_fall))  // [R2]
    else $error("output data changed away from a falling edge");
  cs_end_a: assert property (cs_rise |=> drive_r.oe == 4'h0 && ph_r == PH_OPC)  // [R21]
    else $error("output still driven after select rose");

  // ***************************************************************
  // Power state
  // ***************************************************************
  sfid_power_t pw_nxt;
  logic [TMR_W-1:0] tmr_r;
  logic [TMR_W-1:0] tmr_nxt;
  logic deep_sleep_r;

  // Sleep entry and wake both wait out a delay before settling
  always_comb begin
    pw_nxt = pw_r;
    tmr_nxt = (tmr_r == '0) ? '0 : tmr_r - 1'b1;
    unique case (pw_r)
      PW_STANDBY: if (cs_rise && cmd_r == CM_SLEEP && ph_r == PH_ARMED) begin  // [R6]
        pw_nxt = PW_ENTER;
        tmr_nxt = TMR_W'(SLEEP_ENTRY_CYC - 1);  // [R7]
      end
      PW_ENTER: if (tmr_r == '0) begin
        pw_nxt = PW_SLEEP;  // [R7]
      end
      PW_SLEEP: if (cs_rise && cmd_r == CM_SIG) begin  // [R11] [R13]
        pw_nxt = PW_WAKE;
        tmr_nxt = (ph_r == PH_DUMMY && cnt_r == 5'h00) ? TMR_W'(WAKE_CYC - 1)
                                                       : TMR_W'(WAKE_ID_CYC - 1);
      end
      PW_WAKE: if (tmr_r == '0) begin
        pw_nxt = PW_STANDBY;
      end
    endcase
  end

  // Reset stands for power-up, which always lands awake
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      pw_r <= PW_STANDBY;  // [R10]
      tmr_r <= '0;
      deep_sleep_r <= 1'b0;
    end else begin
      pw_r <= pw_nxt;
      tmr_r <= tmr_nxt;
      deep_sleep_r <= pw_nxt == PW_SLEEP;
    end
  end

  assign deep_sleep_o = deep_sleep_r;

  sleep_entry_a: assert property ($past(pw_r) == PW_ENTER && pw_r == PW_SLEEP  // [R7]
      |-> $past(tmr_r) == '0)
    else $error("deep sleep entered before the entry delay ran out");
  wake_start_a: assert property (pw_r == PW_SLEEP && cs_rise && cmd_r == CM_SIG  // [R11]
      && ph_r == PH_DUMMY && cnt_r == 5'h00 |=> pw_r == PW_WAKE
      && tmr_r == TMR_W'(WAKE_CYC - 1))
    else $error("wake delay not started after plain wake opcode");
  sleep_flag_a: assert property ($rose(deep_sleep_o) |-> $past(pw_r) == PW_ENTER)  // [R7]
    else $error("sleep output rose without passing the entry delay");

  sleep_seen_c: cover property (pw_r == PW_ENTER ##1 pw_r == PW_SLEEP);
  wake_seen_c: cover property (pw_r == PW_WAKE ##1 pw_r == PW_STANDBY);
  secure_out_c: cover property (cmd_r == CM_SECURE && pop_valid && pop_ready);
  quad_out_c: cover property (cmd_r == CM_QUAD && drive_r.oe == 4'hf);

endmodule

// [tb/sfid_host.sv]
`timescale 1ns/1ps
// Host controller model; its link clock idles low and stands still between frames
module sfid_host (
  // Device side
  output sfid_pkg::sfid_pins_t pins_o,
  input wire sfid_pkg::sfid_drive_t drive_i
);
  import sfid_pkg::*;
  initial pins_o = PINS_IDLE;
  // One frame: opcode on line 0, then the rest of ntx bits and nrx bits at w lines per clock
  task automatic frame(input logic [63:0] tx, input int ntx, input int nrx,
                       output logic [31:0] rx, output logic oe_seen, input int w = 1);
    logic [63:0] sr;
    int k;
    sr = tx << (64 - ntx);
    rx = '0;
    oe_seen = 1'b0;
    k = 1;
    // Pins move by non-blocking assignment so the device never races the host
    pins_o.cs_n <= 1'b0;
    for (int i = 0; i < ntx; i += k) begin
      // Highest line carries the most significant bit
      k = (i < 8) ? 1 : w;
      pins_o.io <= 4'(sr[63:60] >> (4 - k));
      sr = sr << k;
      #40 pins_o.sclk <= 1'b1;
      #40 pins_o.sclk <= 1'b0;
    end
    for (int i = 0; i < nrx; i += w) begin
      // Released lines toggle so a stale level never passes for data
      pins_o.io <= ~pins_o.io;
      #40 pins_o.sclk <= 1'b1;
      rx = (w == 1) ? {rx[30:0], drive_i.dout[1]}
                    : (rx << w) | 32'(drive_i.dout & 4'((1 << w) - 1));
      oe_seen = oe_seen | drive_i.oe[1];
      #40 pins_o.sclk <= 1'b0;
    end
    #40 pins_o.cs_n <= 1'b1;
    #60;
  endtask
endmodule

// [tb/flash_id_powerdown_secreg_read_tb.sv]
`timescale 1ns/1ps
module flash_id_powerdown_secreg_read_tb;
  import sfid_pkg::*;
  // ***************************************************************
  // Identity values, all arbitrary
  // ***************************************************************
  localparam logic [7:0] MK = 8'h5a;
  localparam logic [7:0] DV = 8'h13;
  localparam logic [7:0] MT = 8'h40;
  localparam logic [7:0] CP = 8'h14;
  logic sys_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic write_in_progress_flag = 1'b0;
  logic quad = 1'b0;
  sfid_secwr_t secwr = '0;
  sfid_pins_t pins;
  sfid_drive_t drive;
  logic sleep;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [31:0] seed = 32'd17008;
  logic [7:0] mem [3][256];
  logic [31:0] rx;
  logic oe;

  sfid_core #(.MAKER_ID(MK), .DEVICE_ID(DV), .MEM_TYPE(MT), .CAPACITY(CP)) dut (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .pins_i(pins), .drive_o(drive),
    .write_in_progress_flag_i(write_in_progress_flag), .quad_lines_enable_i(quad), .secwr_i(secwr),
    .deep_sleep_o(sleep));
  sfid_host host (.pins_o(pins), .drive_i(drive));

  initial forever #5 sys_clk_i = ~sys_clk_i;
  // Hang guard, far above the roughly 8200 cycles the sequence needs
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      summarize();
    end
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task summarize();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Storage write pulse, mirrored into the reference array
  task wr(input int r, input int a, input logic [7:0] d);
    @(posedge sys_clk_i);
    secwr <= '{en: 1'b1, reg_sel: r[1:0], addr: a[7:0], data: d};
    mem[r][a] = d;
    @(posedge sys_clk_i);
    secwr.en <= 1'b0;
  endtask
  task cycles(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask

  initial begin
    int a;
    logic [31:0] d;
    foreach (mem[r, b]) mem[r][b] = 8'hff;
    cycles(6);
    nrst_i <= 1'b1;
    cycles(5);
    host.frame(OPC_THREE_ID, 8, 24, rx, oe);
    chk("three_id", {8'h00, MK, MT, CP}, rx);
    host.frame({OPC_MAKER_PART, 24'h0}, 32, 16, rx, oe);
    chk("maker_part", {16'h0, MK, DV}, rx);
    host.frame({OPC_WAKE, 24'h0}, 32, 16, rx, oe);
    chk("signature", {16'h0, DV, DV}, rx);
    // Two-line read; the mode byte carries its second pair as one, zero
    host.frame({OPC_DUAL_ID, 24'h0, 8'h20}, 40, 32, rx, oe, 2);
    chk("dual_id", {MK, DV, MK, DV}, rx);
    // Four-line read: refused with the quad lines off, then both start bytes
    host.frame({OPC_QUAD_ID, 24'h01, 8'h20, 16'h0}, 56, 32, rx, oe, 4);
    chk("quad_off_oe", 32'h0, {31'h0, oe});
    quad <= 1'b1;
    host.frame({OPC_QUAD_ID, 24'h01, 8'h20, 16'h0}, 56, 32, rx, oe, 4);
    chk("quad_swap", {DV, MK, DV, MK}, rx);
    host.frame({OPC_QUAD_ID, 24'h00, 8'h20, 16'h0}, 56, 32, rx, oe, 4);
    chk("quad_plain", {MK, DV, MK, DV}, rx);
    // Last byte of the first register checks the wrap to byte zero
    for (int r = 0; r < 3; r++) begin
      d = xs();
      a = (r == 0) ? 255 : int'(d[15:8]);
      wr(r, a, d[7:0]);
      d = xs();
      wr(r, (a + 1) % 256, d[7:0]);
      host.frame({OPC_SECURE_READ, 8'h00, 4'(r + 1), 3'b0, 9'(a), 8'h0}, 40, 16, rx, oe);
      chk("secure", {16'h0, mem[r][a], mem[r][(a + 1) % 256]}, rx);
    end
    host.frame({OPC_SECURE_READ, 8'h00, 4'h4, 12'h000, 8'h0}, 40, 16, rx, oe);
    chk("secure_bad", 32'hffff, rx);
    // Busy engine: three-byte id, secure read, signature and sleep are refused
    @(posedge sys_clk_i);
    write_in_progress_flag <= 1'b1;
    host.frame(OPC_THREE_ID, 8, 24, rx, oe);
    chk("busy_three_oe", 32'h0, {31'h0, oe});
    host.frame({OPC_SECURE_READ, 32'h0}, 40, 8, rx, oe);
    chk("busy_secure_oe", 32'h0, {31'h0, oe});
    host.frame({OPC_WAKE, 24'h0}, 32, 8, rx, oe);
    chk("busy_sig_oe", 32'h0, {31'h0, oe});
    host.frame(OPC_SLEEP, 8, 0, rx, oe);
    cycles(SLEEP_ENTRY_CYC + 10);
    chk("busy_sleep", 32'h0, {31'h0, sleep});
    write_in_progress_flag <= 1'b0;
    host.frame({OPC_SLEEP, 8'h00}, 16, 0, rx, oe);
    cycles(SLEEP_ENTRY_CYC + 10);
    chk("late_sleep", 32'h0, {31'h0, sleep});
    host.frame(OPC_SLEEP, 8, 0, rx, oe);
    chk("entry_wait", 32'h0, {31'h0, sleep});
    cycles(SLEEP_ENTRY_CYC + 5);
    chk("asleep", 32'h1, {31'h0, sleep});
    host.frame(OPC_THREE_ID, 8, 24, rx, oe);
    chk("asleep_oe", 32'h0, {31'h0, oe});
    host.frame(OPC_WAKE, 8, 0, rx, oe);
    cycles(WAKE_CYC + 10);
    chk("woken", 32'h0, {31'h0, sleep});
    host.frame(OPC_THREE_ID, 8, 24, rx, oe);
    chk("three_id_again", {8'h00, MK, MT, CP}, rx);
    // Asleep again, then woken by the form that returns the device byte
    host.frame(OPC_SLEEP, 8, 0, rx, oe);
    cycles(SLEEP_ENTRY_CYC + 5);
    chk("asleep_again", 32'h1, {31'h0, sleep});
    host.frame({OPC_WAKE, 24'h0}, 32, 8, rx, oe);
    chk("sleep_sig", {24'h0, DV}, rx);
    cycles(WAKE_ID_CYC + 10);
    chk("woken_id", 32'h0, {31'h0, sleep});
    host.frame(OPC_THREE_ID, 8, 24, rx, oe);
    chk("three_id_last", {8'h00, MK, MT, CP}, rx);
    summarize();
  end
endmodule
